/* File: logic/pamm_pkg.sv */
package pamm_pkg;
   localparam int OPC_W = 32;
   localparam int ACC_W = 40;
   localparam int WORD_W = 16;
   localparam int EXT_W = 17;
   localparam int PROD_W = 32;
   localparam int NUM_TA = 8;
   localparam int TA_IDX_W = 3;
   // First opcode byte of the paired modify-and-multiply instruction
   localparam logic [7:0] OP_MUL_PAIR = 8'h82;
   // Instruction-specific selects supplied by the decoder
   localparam logic [2:0] CMD_NONE = 3'h0;
   // Low nibble of the two register-move encodings
   localparam logic [3:0] MOVE_NIB_A = 4'h1;
   localparam logic [3:0] MOVE_NIB_B = 4'h9;
   localparam logic [3:0] LOADP_NIB_A = 4'h5;
   localparam logic [3:0] LOADP_NIB_B = 4'hd;
   localparam logic [7:0] MOVE_HI = 8'h14;
   localparam logic [2:0] LOAD_D16_LEN = 3'h4;
   localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
   localparam logic [WORD_W-1:0] TA_RESET = 16'h0000;
   localparam logic [ACC_W-1:0] RND_BIAS = 40'h00_0000_8000;
   localparam logic [ACC_W-1:0] SAT_POS40 = 40'h7f_ffff_ffff;
   localparam logic [ACC_W-1:0] SAT_NEG40 = 40'h80_0000_0000;
   localparam logic [ACC_W-1:0] SAT_POS32 = 40'h00_7fff_ffff;
   localparam logic [ACC_W-1:0] SAT_NEG32 = 40'hff_8000_0000;
   localparam logic [PROD_W-1:0] MULTIPLY_SATURATION_BIT_POS = 32'h7fff_ffff;
   localparam logic [PROD_W-1:0] MULTIPLY_SATURATION_BIT_TRIG = 32'h4000_0000;

   typedef enum logic [2:0] {
      pamm_op_none = 3'b000,
      pamm_op_mpy = 3'b001,
      pamm_op_mas = 3'b011,
      pamm_op_modonly = 3'b010,
      pamm_op_move = 3'b110,
      pamm_op_loadp = 3'b111,
      pamm_op_loadd = 3'b101
   } pamm_op_type;

   typedef struct packed {
      logic fractional_mode_bit;
      logic wide_overflow_mode_bit;
      logic rounding_mode_bit;
      logic datapath_saturation_bit;
      logic multiply_saturation_bit;
      logic sign_extension_mode_bit;
   } pamm_status_type;

   typedef struct packed {
      logic [WORD_W-1:0] x_word;
      logic [WORD_W-1:0] y_word;
      logic [WORD_W-1:0] coef_word;
   } pamm_operands_type;

   typedef struct packed {
      logic upd_x;
      logic upd_y;
      logic upd_coef;
      logic [WORD_W-1:0] x_addr_nxt;
      logic [WORD_W-1:0] y_addr_nxt;
      logic [WORD_W-1:0] coef_addr_nxt;
   } pamm_aux_type;
endpackage

/* File: logic/pamm_mul.sv */
module pamm_mul
   import pamm_pkg::*;
(
   input wire logic [WORD_W-1:0] y_word,
   input wire logic [WORD_W-1:0] coef_word,
   input wire logic uns_y,
   input wire logic uns_coef,
   input wire pamm_status_type status,
   output logic [ACC_W-1:0] product_ext
);
   logic [EXT_W-1:0] y_ext;
   logic [EXT_W-1:0] c_ext;
   logic signed [2*EXT_W-1:0] raw;
   logic [PROD_W-1:0] prod;
   logic multiply_saturation_bit_hit;

   always_comb begin
      // Unsigned operands zero extend, others follow the sign mode bit
      y_ext = (uns_y || !status.sign_extension_mode_bit) ? {1'b0, y_word}
         : {y_word[WORD_W-1], y_word};
      c_ext = (uns_coef || !status.sign_extension_mode_bit) ? {1'b0, coef_word}
         : {coef_word[WORD_W-1], coef_word};
      raw = $signed(y_ext) * $signed(c_ext);
      if (status.fractional_mode_bit) begin
         prod = {raw[PROD_W-2:0], 1'b0};
      end else begin
         prod = raw[PROD_W-1:0];
      end
      // With both operands sign extended, only -1 * -1 in fractional mode can leave the 32-bit product range
      multiply_saturation_bit_hit = status.multiply_saturation_bit && status.fractional_mode_bit
         && !uns_y && !uns_coef && (raw[PROD_W-1:0] == MULTIPLY_SATURATION_BIT_TRIG);
      if (multiply_saturation_bit_hit) begin
         prod = MULTIPLY_SATURATION_BIT_POS;
      end
      product_ext = {{(ACC_W-PROD_W){prod[PROD_W-1]}}, prod};
   end
endmodule // pamm_mul

/* File: logic/pamm_path.sv */
// Contract
// - Aux register update and multiply finish together in one cycle.
// - Aux update comes from the first dual operand's addressing.
// - Coefficient operand is fetched via coefficient pointer addressing.
// - Both multiplier inputs widen to 17 bits, method chosen per operand.
// - Unsigned qualifier zero extends the operand to 17 bits.
// - Without unsigned qualifier, sign extend under the sign mode bit.
// - Fractional mode shifts the product left by one bit.
// - Product overflow handling follows the multiply saturation bit.
// - Multiply-subtract subtracts the 40-bit extended product from source.
// - Plain multiply puts the 40-bit extended product in the accumulator.
// - Round qualifier rounds per rounding mode; otherwise no rounding.
// - Overflow detection per wide mode bit sets accumulator overflow flag.
// - Overflowed result saturates when datapath saturation bit is set.
// - The 40 qualifier forces wide mode for one instruction only.
// - Aux-modify-only forms update each of three address units alone.
// - Paired multiply instruction decodes from first byte 10000010.
// - Address register moves and loads run in address phase, no memory.
// - Program-label load writes an 8-bit unsigned value to target register.
// - Data-address load writes a signed 16-bit constant to target register.
// - Data-address load is 4 bytes, one cycle, never parallel enabled.
// - Register move has final nibble 0001 or 1001 by pair position.
module pamm_path
   import pamm_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [OPC_W-1:0] instr_word,
   input wire logic [2:0] instr_len,
   input wire logic parallel_enable,
   input wire pamm_op_type decoded_op,
   input wire logic uns_y,
   input wire logic uns_coef,
   input wire logic round_q,
   input wire logic wide_q,
   input wire logic [1:0] acc_sel,
   input wire logic [TA_IDX_W-1:0] src_ta,
   input wire logic [TA_IDX_W-1:0] dst_ta,
   input wire logic [7:0] program_label_operand,
   input wire logic [WORD_W-1:0] data_address_constant,
   input wire pamm_status_type status,
   input wire pamm_operands_type operands,
   input wire pamm_aux_type aux_in,
   input wire logic [WORD_W-1:0] coefficient_pointer,
   output logic [WORD_W-1:0] coef_fetch_addr,
   output logic [WORD_W-1:0] x_aux_r,
   output logic [WORD_W-1:0] y_aux_r,
   output logic [WORD_W-1:0] coef_aux_r,
   output logic [ACC_W-1:0] acc0_r,
   output logic [ACC_W-1:0] acc1_r,
   output logic [ACC_W-1:0] acc2_r,
   output logic [ACC_W-1:0] acc3_r,
   output logic [3:0] accumulator_overflow_flag_r,
   output logic [WORD_W-1:0] ta_out_r,
   output logic illegal_r,
   output logic data_mem_access
);
   logic [ACC_W-1:0] acc_mem [4];
   logic [WORD_W-1:0] ta_r [NUM_TA];
   logic [ACC_W-1:0] source_accumulator;
   logic [ACC_W-1:0] product_ext;
   logic [ACC_W:0] sum;
   logic [ACC_W:0] rounded;
   logic [ACC_W-1:0] result_nxt;
   logic ovf;
   logic wide_eff;
   logic is_mul;
   logic mul_ok;
   logic ta_ok;
   logic ta_write;
   logic [WORD_W-1:0] ta_nxt;
   logic illegal_nxt;

   // The coefficient fetch address always comes from the coefficient pointer
   assign coef_fetch_addr = coefficient_pointer;
   // Address-phase forms never touch data memory
   assign data_mem_access = instr_valid && is_mul;

   assign is_mul = (decoded_op == pamm_op_mpy) || (decoded_op == pamm_op_mas);
   assign mul_ok = is_mul && (instr_word[OPC_W-1:OPC_W-8] == OP_MUL_PAIR);

   always_comb begin
      source_accumulator = acc_mem[acc_sel];
   end

   pamm_mul u_mul (
      .y_word(operands.y_word),
      .coef_word(operands.coef_word),
      .uns_y(uns_y),
      .uns_coef(uns_coef),
      .status(status),
      .product_ext(product_ext)
   );

   always_comb begin
      wide_eff = status.wide_overflow_mode_bit || wide_q;
      if (decoded_op == pamm_op_mas) begin
         sum = {source_accumulator[ACC_W-1], source_accumulator}
            - {product_ext[ACC_W-1], product_ext};
      end else begin
         sum = {product_ext[ACC_W-1], product_ext};
      end
      rounded = sum;
      if (round_q) begin
         rounded = sum + {RND_BIAS[ACC_W-1], RND_BIAS};
         // Round-to-nearest-even when the rounding mode bit asks for it
         if (status.rounding_mode_bit && (sum[15:0] == 16'h8000)) begin
            rounded[16] = 1'b0;
         end
         rounded[15:0] = 16'h0000;
      end
      if (wide_eff) begin
         ovf = rounded[ACC_W] != rounded[ACC_W-1];
      end else begin
         ovf = rounded[ACC_W] != rounded[31] || rounded[ACC_W-1:31] != {9{rounded[31]}};
      end
      result_nxt = rounded[ACC_W-1:0];
      if (ovf && status.datapath_saturation_bit) begin
         if (wide_eff) begin
            result_nxt = rounded[ACC_W] ? SAT_NEG40 : SAT_POS40;
         end else begin
            result_nxt = rounded[ACC_W] ? SAT_NEG32 : SAT_POS32;
         end
      end
   end

   // Accumulator write-back into the source accumulator
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            acc_mem[i] <= ACC_RESET;
         end
      end else if (instr_valid && mul_ok) begin
         acc_mem[acc_sel] <= result_nxt;
      end
   end

   assign acc0_r = acc_mem[0];
   assign acc1_r = acc_mem[1];
   assign acc2_r = acc_mem[2];
   assign acc3_r = acc_mem[3];

   // Sticky overflow flags; only reset clears them, there is no clear input
   always_ff @(posedge clock) begin
      if (rst) begin
         accumulator_overflow_flag_r <= 4'h0;
      end else if (instr_valid && mul_ok && ovf) begin
         accumulator_overflow_flag_r[acc_sel] <= 1'b1;
      end
   end

   // Aux register updates; paired multiply updates x_aux_r in the same edge as the accumulator write
   always_ff @(posedge clock) begin
      if (rst) begin
         x_aux_r <= TA_RESET;
         y_aux_r <= TA_RESET;
         coef_aux_r <= TA_RESET;
      end else if (instr_valid) begin
         if (mul_ok) begin
            x_aux_r <= aux_in.x_addr_nxt;
         end else if (decoded_op == pamm_op_modonly) begin
            if (aux_in.upd_x) begin
               x_aux_r <= aux_in.x_addr_nxt;
            end
            if (aux_in.upd_y) begin
               y_aux_r <= aux_in.y_addr_nxt;
            end
            if (aux_in.upd_coef) begin
               coef_aux_r <= aux_in.coef_addr_nxt;
            end
         end
      end
   end

   // Address-register move and load forms
   always_comb begin
      ta_write = 1'b0;
      ta_ok = 1'b0;
      ta_nxt = TA_RESET;
      unique case (decoded_op)
         pamm_op_move: begin
            ta_ok = (instr_word[OPC_W-1:OPC_W-7] == MOVE_HI[7:1])
               && (instr_word[11:8] == MOVE_NIB_A || instr_word[11:8] == MOVE_NIB_B);
            ta_nxt = ta_r[src_ta];
         end
         pamm_op_loadp: begin
            ta_ok = 1'b1;
            ta_nxt = {8'h00, program_label_operand};
         end
         pamm_op_loadd: begin
            // Long form: four bytes and no parallel pairing
            ta_ok = (instr_len == LOAD_D16_LEN) && !parallel_enable;
            ta_nxt = data_address_constant;
         end
         default: begin
            ta_ok = 1'b0;
         end
      endcase
      ta_write = instr_valid && ta_ok;
      illegal_nxt = instr_valid && (
         (is_mul && !mul_ok)
         || ((decoded_op == pamm_op_move || decoded_op == pamm_op_loadd) && !ta_ok));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < NUM_TA; i++) begin
            ta_r[i] <= TA_RESET;
         end
      end else if (ta_write) begin
         ta_r[dst_ta] <= ta_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ta_out_r <= TA_RESET;
      end else if (ta_write) begin
         ta_out_r <= ta_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         illegal_r <= 1'b0;
      end else begin
         illegal_r <= illegal_nxt;
      end
   end
endmodule // pamm_path

/* File: verification/pamm_coef_mem.sv */
module pamm_coef_mem
   import pamm_pkg::*;
(
   input wire logic [WORD_W-1:0] addr,
   output logic [WORD_W-1:0] word
);
   timeunit 1ns;
   timeprecision 1ns;
   // Internal coefficient space only; no external window is modelled
   always_comb begin
      case (addr[1:0])
         2'h0: word = 16'h7fff;
         2'h1: word = 16'h8000;
         2'h2: word = 16'hfffe;
         default: word = 16'h0002;
      endcase
   end
endmodule // pamm_coef_mem

/* File: verification/pamm_path_sva.sv */
module pamm_path_chk
   import pamm_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [OPC_W-1:0] instr_word,
   input wire logic [2:0] instr_len,
   input wire logic parallel_enable,
   input wire pamm_op_type decoded_op,
   input wire logic [7:0] program_label_operand,
   input wire logic [WORD_W-1:0] data_address_constant,
   input wire pamm_aux_type aux_in,
   input wire logic [WORD_W-1:0] coefficient_pointer,
   input wire logic [WORD_W-1:0] coef_fetch_addr,
   input wire logic [WORD_W-1:0] x_aux_r,
   input wire logic [WORD_W-1:0] y_aux_r,
   input wire logic [ACC_W-1:0] acc0_r,
   input wire logic [3:0] accumulator_overflow_flag_r,
   input wire logic [WORD_W-1:0] ta_out_r,
   input wire logic illegal_r,
   input wire logic data_mem_access
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic mul_v;
   logic ld_v;
   assign mul_v = instr_valid && (decoded_op == pamm_op_mpy || decoded_op == pamm_op_mas);
   assign ld_v = instr_valid && decoded_op == pamm_op_loadd;
   coef_addr_a: assert property (coef_fetch_addr == coefficient_pointer)
      else $error("coef address");
   mem_access_a: assert property (data_mem_access == mul_v)
      else $error("memory access flag");
   aux_pair_a: assert property (mul_v && instr_word[31:24] == OP_MUL_PAIR && aux_in.upd_x
      |=> x_aux_r == $past(aux_in.x_addr_nxt) && $stable(y_aux_r)) else $error("aux pair");
   bad_opcode_a: assert property (mul_v && instr_word[31:24] != OP_MUL_PAIR
      |=> illegal_r && $stable(acc0_r)) else $error("bad opcode taken");
   load_refuse_a: assert property (ld_v && (instr_len != LOAD_D16_LEN || parallel_enable)
      |=> illegal_r && $stable(ta_out_r)) else $error("load not refused");
   load_const_a: assert property (ld_v && instr_len == LOAD_D16_LEN && !parallel_enable
      |=> ta_out_r == $past(data_address_constant) && !illegal_r) else $error("load value");
   label_load_a: assert property (instr_valid && decoded_op == pamm_op_loadp
      |=> ta_out_r == {8'h00, $past(program_label_operand)}) else $error("label value");
   flag_sticky_a: assert property (1'b1 |=> (accumulator_overflow_flag_r &
      $past(accumulator_overflow_flag_r)) == $past(accumulator_overflow_flag_r))
      else $error("flag cleared");
endmodule // pamm_path_chk
bind pamm_path pamm_path_chk pamm_path_chk_i (.clock, .rst, .instr_valid, .instr_word,
   .instr_len, .parallel_enable, .decoded_op, .program_label_operand, .data_address_constant,
   .aux_in, .coefficient_pointer, .coef_fetch_addr, .x_aux_r, .y_aux_r, .acc0_r,
   .accumulator_overflow_flag_r, .ta_out_r, .illegal_r, .data_mem_access);

/* File: verification/test_parallel_addr_modify_multiply_path.sv */
module test_parallel_addr_modify_multiply_path;
   import pamm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [OPC_W-1:0] instr_word = 32'h8200_0000;
   logic [2:0] instr_len = 3'h4;
   logic parallel_enable = 1'b0;
   pamm_op_type decoded_op = pamm_op_none;
   logic uns_y = 1'b0;
   logic uns_coef = 1'b0;
   logic round_q = 1'b0;
   logic wide_q = 1'b0;
   logic [1:0] acc_sel = 2'h0;
   logic [TA_IDX_W-1:0] src_ta = 3'h0;
   logic [TA_IDX_W-1:0] dst_ta = 3'h0;
   logic [7:0] label = 8'h00;
   logic [15:0] dconst = 16'h0000;
   pamm_status_type status = 6'h01;
   logic [15:0] y_word = 16'h0000;
   logic [15:0] coef_word;
   pamm_operands_type operands;
   pamm_aux_type aux_in = '{1'b1, 1'b0, 1'b0, 16'h0040, 16'h0050, 16'h0060};
   logic [15:0] coefficient_pointer = 16'h0000;
   logic [15:0] coef_fetch_addr, x_aux_r, y_aux_r, coef_aux_r, ta;
   logic [39:0] acc [4];
   logic [3:0] flags;
   logic illegal, dma, dma_seen;
   int n_mismatch = 0;
   int n_compared = 0;
   assign operands = '{16'h0000, y_word, coef_word};
   pamm_path pamm_path_i (
      .clock, .rst, .instr_valid, .instr_word, .instr_len, .parallel_enable, .decoded_op,
      .uns_y, .uns_coef, .round_q, .wide_q, .acc_sel, .src_ta, .dst_ta,
      .program_label_operand(label), .data_address_constant(dconst), .status, .operands,
      .aux_in, .coefficient_pointer, .coef_fetch_addr, .x_aux_r, .y_aux_r, .coef_aux_r,
      .acc0_r(acc[0]), .acc1_r(acc[1]), .acc2_r(acc[2]), .acc3_r(acc[3]),
      .accumulator_overflow_flag_r(flags), .ta_out_r(ta), .illegal_r(illegal),
      .data_mem_access(dma));
   pamm_coef_mem pamm_coef_mem_i (.addr(coef_fetch_addr), .word(coef_word));
   initial forever #25 clock = ~clock;
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Valid stays up so instructions run back to back; idle drops it
   task automatic fire();
      instr_valid = 1'b1;
      #1 dma_seen = dma;
      @(negedge clock);
   endtask
   task automatic idle(input string name);
      instr_valid = 1'b0;
      @(negedge clock);
      $display("test %s done", name);
   endtask
   task automatic mul(input pamm_op_type op, input logic [1:0] a, input logic [15:0] y,
      input logic [1:0] cp, input logic [39:0] exp);
      decoded_op = op;
      acc_sel = a;
      y_word = y;
      coefficient_pointer = {14'h0000, cp};
      fire();
      check(acc[a], exp);
   endtask
   task automatic t_mul();
      mul(pamm_op_mpy, 2'h0, 16'h0003, 2'h2, 40'hff_ffff_fffa);
      check(dma_seen, 1'b1);
      check(x_aux_r, 16'h0040);
      check(y_aux_r, 16'h0000);
      uns_y = 1'b1;
      mul(pamm_op_mpy, 2'h1, 16'hffff, 2'h2, 40'hff_fffe_0002);
      uns_y = 1'b0;
      status = 6'h00;
      mul(pamm_op_mpy, 2'h1, 16'hffff, 2'h3, 40'h00_0001_fffe);
      uns_coef = 1'b1;
      mul(pamm_op_mpy, 2'h1, 16'h0003, 2'h1, 40'h00_0001_8000);
      round_q = 1'b1;
      mul(pamm_op_mpy, 2'h1, 16'h0003, 2'h1, 40'h00_0002_0000);
      // A tie with the rounding mode bit set rounds to even
      status = 6'h08;
      mul(pamm_op_mpy, 2'h1, 16'h0001, 2'h1, 40'h00_0000_0000);
      round_q = 1'b0;
      uns_coef = 1'b0;
      status = 6'h21;
      mul(pamm_op_mpy, 2'h0, 16'h0003, 2'h2, 40'hff_ffff_fff4);
      status = 6'h23;
      mul(pamm_op_mpy, 2'h0, 16'h8000, 2'h1, 40'h00_7fff_ffff);
      idle("multiply");
   endtask
   task automatic t_mas();
      status = 6'h25;
      mul(pamm_op_mpy, 2'h2, 16'h8000, 2'h0, 40'hff_8001_0000);
      mul(pamm_op_mas, 2'h2, 16'h7fff, 2'h0, SAT_NEG32);
      check(flags, 4'h4);
      wide_q = 1'b1;
      mul(pamm_op_mpy, 2'h3, 16'h8000, 2'h0, 40'hff_8001_0000);
      mul(pamm_op_mas, 2'h3, 16'h7fff, 2'h0, 40'hff_0002_fffe);
      check(flags, 4'h4);
      wide_q = 1'b0;
      mul(pamm_op_mas, 2'h3, 16'h7fff, 2'h0, SAT_NEG32);
      check(flags, 4'hc);
      instr_word = 32'h8300_0000;
      mul(pamm_op_mpy, 2'h0, 16'h0001, 2'h3, 40'h00_7fff_ffff);
      check(illegal, 1'b1);
      instr_word = 32'h8200_0000;
      idle("subtract");
   endtask
   task automatic t_mod();
      aux_in = '{1'b0, 1'b1, 1'b1, 16'h0041, 16'h0051, 16'h0061};
      decoded_op = pamm_op_modonly;
      fire();
      check(y_aux_r, 16'h0051);
      check(coef_aux_r, 16'h0061);
      check(x_aux_r, 16'h0040);
      check(dma_seen, 1'b0);
      idle("modify");
   endtask
   task automatic t_addr();
      decoded_op = pamm_op_loadp;
      instr_word = 32'h1400_0500;
      label = 8'hff;
      dst_ta = 3'h1;
      fire();
      check(ta, 16'h00ff);
      check(dma_seen, 1'b0);
      decoded_op = pamm_op_loadd;
      dconst = 16'h8001;
      dst_ta = 3'h2;
      fire();
      check(ta, 16'h8001);
      dconst = 16'h1111;
      instr_len = 3'h3;
      fire();
      check(illegal, 1'b1);
      instr_len = 3'h4;
      parallel_enable = 1'b1;
      fire();
      check(illegal, 1'b1);
      parallel_enable = 1'b0;
      decoded_op = pamm_op_move;
      src_ta = 3'h1;
      dst_ta = 3'h3;
      instr_word = 32'h1400_0900;
      fire();
      check(ta, 16'h00ff);
      src_ta = 3'h2;
      instr_word = 32'h1400_0100;
      fire();
      check(ta, 16'h8001);
      src_ta = 3'h1;
      instr_word = 32'h1400_0500;
      fire();
      check(illegal, 1'b1);
      check(ta, 16'h8001);
      idle("address");
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(negedge clock);
      rst = 1'b0;
      check(acc[0], ACC_RESET);
      check(flags, 4'h0);
      t_mul();
      t_mas();
      t_mod();
      t_addr();
      report_and_stop();
   end
endmodule // test_parallel_addr_modify_multiply_path
